// >>> cbu_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit #(
    parameter int PC_W = cbu_pkg::PC_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [cbu_pkg::INSTR_W-1:0] instr_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [cbu_pkg::STATUS_W-1:0] status_i,
    output logic busy_o,
    output logic match_o,
    output logic pc_we_o,
    output logic [PC_W-1:0] pc_o,
    output logic nop_o,
    output logic done_o,
    output logic taken_o
);
    function automatic logic is_branch(input logic [7:0] opc);
        is_branch = (opc == cbu_pkg::OPC_BR_CARRY_CLEAR) || (opc == cbu_pkg::OPC_BR_NEG_CLEAR);
    endfunction

    cbu_pkg::cbu_state_e state;
    logic [1:0] phase;
    logic [7:0] opc;
    logic [7:0] offset;
    logic [PC_W-1:0] pc_next_word;
    logic cond;
    logic take;
    logic [PC_W-1:0] target;
    logic accept;
    logic exec_last;
    logic flush_last;

    cbu_target_calc #(.PC_W(PC_W)) u_calc (
        .pc_i(pc_next_word),
        .offset_i(offset),
        .target_o(target)
    );

    always_comb
    begin
        cond = 1'b0;
        if (opc == cbu_pkg::OPC_BR_CARRY_CLEAR)
        begin
            cond = ~status_i[cbu_pkg::CARRY_BIT];
        end
        else if (opc == cbu_pkg::OPC_BR_NEG_CLEAR)
        begin
            cond = ~status_i[cbu_pkg::NEGATIVE_BIT];
        end
    end

    // condition is sampled in the process phase
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            take <= 1'b0;
        end
        else if (state == cbu_pkg::CBU_EXEC && phase == cbu_pkg::PHASE_PROCESS)
        begin
            take <= cond;
        end
    end

    // capture: an accepted request in idle latches opcode, offset and advanced counter
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            opc <= 8'h00;
            offset <= 8'h00;
            pc_next_word <= cbu_pkg::PC_RESET;
        end
        else if (accept)
        begin
            opc <= instr_i[15:8];
            offset <= instr_i[7:0];
            pc_next_word <= pc_i + PC_W'(cbu_pkg::PC_STEP);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= cbu_pkg::CBU_IDLE;
            phase <= cbu_pkg::PHASE_DECODE;
        end
        else
        begin
            unique case (state)
                cbu_pkg::CBU_IDLE:
                begin
                    phase <= cbu_pkg::PHASE_READ;
                    if (accept)
                    begin
                        state <= cbu_pkg::CBU_EXEC;
                    end
                end
                cbu_pkg::CBU_EXEC:
                begin
                    phase <= phase + 2'h1;
                    if (phase == cbu_pkg::PHASE_WRITE)
                    begin
                        state <= take ? cbu_pkg::CBU_FLUSH : cbu_pkg::CBU_IDLE;
                    end
                end
                cbu_pkg::CBU_FLUSH:
                begin
                    phase <= phase + 2'h1;
                    if (phase == cbu_pkg::PHASE_WRITE)
                    begin
                        state <= cbu_pkg::CBU_IDLE;
                    end
                end
                default:
                begin
                    state <= cbu_pkg::CBU_IDLE;
                end
            endcase
        end
    end

    // sequencer positions shared by the output registers
    always_comb
    begin
        accept = (state == cbu_pkg::CBU_IDLE) && instr_valid_i && is_branch(instr_i[15:8]);
        exec_last = (state == cbu_pkg::CBU_EXEC) && (phase == cbu_pkg::PHASE_WRITE);
        flush_last = (state == cbu_pkg::CBU_FLUSH) && (phase == cbu_pkg::PHASE_WRITE);
    end

    // outputs registered; the unit never drives status, so flags stay untouched
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            match_o <= 1'b0;
        end
        else
        begin
            match_o <= accept;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'b0;
        end
        else
        begin
            busy_o <= accept
                || (state == cbu_pkg::CBU_EXEC && !(exec_last && !take))
                || (state == cbu_pkg::CBU_FLUSH && !flush_last);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_we_o <= 1'b0;
        end
        else
        begin
            pc_we_o <= exec_last && take;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_o <= cbu_pkg::PC_RESET;
        end
        else if (exec_last && take)
        begin
            pc_o <= target;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            taken_o <= 1'b0;
        end
        else if (exec_last)
        begin
            taken_o <= take;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= (exec_last && !take) || flush_last;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nop_o <= 1'b0;
        end
        else
        begin
            nop_o <= (exec_last && take)
                || (state == cbu_pkg::CBU_FLUSH && !flush_last);
        end
    end
endmodule
`default_nettype wire

// >>> cbu_pkg.sv
package cbu_pkg;
    // opcode upper bytes
    localparam logic [7:0] OPC_BR_CARRY_CLEAR = 8'he3;
    localparam logic [7:0] OPC_BR_NEG_CLEAR = 8'he7;
    localparam int INSTR_W = 16;
    localparam int PC_W = 21;
    localparam int OFFSET_W = 8;
    localparam int STATUS_W = 8;
    localparam int CARRY_BIT = 0;
    localparam int NEGATIVE_BIT = 4;
    localparam int PC_STEP = 2;
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_DECODE = 2'h0;
    localparam logic [1:0] PHASE_READ = 2'h1;
    localparam logic [1:0] PHASE_PROCESS = 2'h2;
    localparam logic [1:0] PHASE_WRITE = 2'h3;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    typedef enum logic [1:0] {CBU_IDLE, CBU_EXEC, CBU_FLUSH} cbu_state_e;
endpackage

// >>> cbu_target_calc.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_target_calc #(
    parameter int PC_W = 21
) (
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [7:0] offset_i,
    output logic [PC_W-1:0] target_o
);
    // pc_i has already advanced by two past the branch word
    always_comb
    begin
        target_o = pc_i + {{(PC_W-9){offset_i[7]}}, offset_i, 1'b0};
    end
endmodule
`default_nettype wire

// >>> cbu_branch_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit_chk #(
    parameter int PC_W = 21
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [cbu_pkg::INSTR_W-1:0] instr_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [cbu_pkg::STATUS_W-1:0] status_i,
    input wire logic busy_o,
    input wire logic match_o,
    input wire logic pc_we_o,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic nop_o,
    input wire logic done_o,
    input wire logic taken_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    match_busy_a: assert property (match_o |-> busy_o[*3]) else $error("busy gap");
    untaken_end_a: assert property (
        match_o ##3 !pc_we_o |-> done_o && !taken_o && $stable(pc_o))
        else $error("untaken end");
    taken_nop_a: assert property (
        pc_we_o |-> nop_o && taken_o ##1 nop_o[*3] ##1 done_o && !nop_o)
        else $error("taken nop");
    write_delay_a: assert property (pc_we_o |-> $past(match_o, 3)) else $error("we delay");
    carry_gate_a: assert property (
        pc_we_o && $past(instr_i[15:8], 4) == cbu_pkg::OPC_BR_CARRY_CLEAR
        |-> !$past(status_i[cbu_pkg::CARRY_BIT], 2))
        else $error("carry set");
    neg_gate_a: assert property (
        pc_we_o && $past(instr_i[15:8], 4) == cbu_pkg::OPC_BR_NEG_CLEAR
        |-> !$past(status_i[cbu_pkg::NEGATIVE_BIT], 2))
        else $error("negative set");
    untaken_flag_a: assert property (
        done_o && !taken_o && $past(match_o, 3)
        |-> ($past(instr_i[15:8], 4) == cbu_pkg::OPC_BR_CARRY_CLEAR)
            ? $past(status_i[cbu_pkg::CARRY_BIT], 2) : $past(status_i[cbu_pkg::NEGATIVE_BIT], 2))
        else $error("untaken with flag clear");
    target_sum_a: assert property (
        pc_we_o |-> pc_o == PC_W'($past(pc_i, 4) + 2
        + {{(PC_W-9){$past(instr_i[7], 4)}}, $past(instr_i[7:0], 4), 1'b0}))
        else $error("bad target");
endmodule
bind cbu_branch_unit cbu_branch_unit_chk #(.PC_W(PC_W)) chk_i (.clk_sys_i, .rst_n_i, .instr_i,
    .pc_i, .status_i, .busy_o, .match_o, .pc_we_o, .pc_o, .nop_o, .done_o, .taken_o);
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [20:0] pc_i = 21'h000000;
    logic [7:0] status_i = 8'h00;
    logic busy_o, match_o, pc_we_o, nop_o, done_o, taken_o;
    logic [20:0] pc_o;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    cbu_branch_unit cbu_branch_unit_i (.clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i, .pc_i,
        .status_i, .busy_o, .match_o, .pc_we_o, .pc_o, .nop_o, .done_o, .taken_o);
    initial forever #50 clk_sys_i = ~clk_sys_i;
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic exp_take(input logic [7:0] opc, input logic [7:0] st);
        return (opc == cbu_pkg::OPC_BR_CARRY_CLEAR && !st[cbu_pkg::CARRY_BIT])
            || (opc == cbu_pkg::OPC_BR_NEG_CLEAR && !st[cbu_pkg::NEGATIVE_BIT]);
    endfunction
    task automatic run(input logic [7:0] opc, input logic [7:0] off);
        logic br, tk;
        int n_we, t_d, n_m, n_busy, n_nop, ph;
        logic [20:0] cap, tgt;
        br = opc == cbu_pkg::OPC_BR_CARRY_CLEAR || opc == cbu_pkg::OPC_BR_NEG_CLEAR;
        ph = cbu_pkg::PHASES;
        // one spare edge so no input is assigned twice in a time step
        @(negedge clk_sys_i);
        instr_i = {opc, off};
        pc_i = 21'($urandom);
        status_i = 8'($urandom);
        instr_valid_i = 1'b1;
        tk = exp_take(opc, status_i);
        tgt = pc_i + 21'(cbu_pkg::PC_STEP) + {{12{off[7]}}, off, 1'b0};
        n_we = 0;
        t_d = 0;
        n_m = 0;
        n_busy = 0;
        n_nop = 0;
        cap = 21'h0;
        for (int k = 1; k <= 10; k++)
        begin
            @(negedge clk_sys_i);
            // a request while busy must be ignored
            instr_valid_i = br && k == 2;
            if (k == 1)
                check("match", match_o, br);
            if (match_o === 1'b1)
                n_m++;
            if (busy_o === 1'b1)
                n_busy++;
            if (nop_o === 1'b1)
                n_nop++;
            if (done_o === 1'b1)
                t_d = k;
            if (pc_we_o === 1'b1)
            begin
                n_we++;
                cap = pc_o;
            end
        end
        check("done", t_d, br ? (tk ? 2 * ph : ph) : 0);
        check("writes", n_we, tk);
        check("target", cap, tk ? tgt : 21'h0);
        check("matches", n_m, br);
        check("busy", n_busy, br ? (tk ? 2 * ph - 1 : ph - 1) : 0);
        check("nop", n_nop, tk ? ph : 0);
        if (br)
            check("taken", taken_o, tk);
    endtask
    initial
    begin
        void'($urandom(32'h31d9d41a));
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 64; i++)
            run(i % 8 == 7 ? 8'($urandom) : (i[0] ? 8'he7 : 8'he3),
                i < 2 ? 8'h7f + 8'(i) : 8'($urandom));
        tally_and_finish();
    end
endmodule
`default_nettype wire
